// [hw/cstrip_top.sv]
/*
 Coast-stop and external-trip controller of a motor drive, with an
 APB register slave and one level interrupt.
 Assumes terminal pins asynchronous to pclk; run and reset commands
 come from pins too; the output stage obeys drive_enable directly.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cstrip_consts.svh"
module cstrip_top #(
   parameter int TICK_CYCLES = `CSTRIP_TICK_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        coast_stop_input,
   input  wire logic        external_fault_input,
   input  wire logic        run_cmd,
   input  wire logic        reset_terminal,
   output logic             drive_enable,
   output logic             start_from_speed,
   output logic             decel_stop,
   output logic             alarm_out,
   output logic [7:0]       error_code,
   output logic             irq
);
   logic [3:0]  sync_q;
   logic        coast_s;
   logic        fault_s;
   logic        run_s;
   logic        rst_s;
   logic        fault_prev_ff;
   logic        run_prev_ff;
   logic        rst_prev_ff;
   logic        fault_rise;
   logic        run_rise;
   logic        rst_fall;
   logic        clear_req;
   logic        speed_sel_ff;
   logic        lockout_ff;
   logic        sw_reset_ff;
   logic [15:0] delay_ff;
   logic [2:0]  irq_stat_ff;
   logic [2:0]  irq_mask_ff;
   logic [2:0]  irq_evt;
   logic        armed_ff;
   logic [15:0] delay_cnt_ff;
   logic [31:0] tick_cnt_ff;
   logic        tick;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [31:0] nxt_prdata;
   cstrip_pkg::cstrip_state_t state_ff;
   cstrip_pkg::cstrip_state_t nxt_state;

   cstrip_sync #(.WIDTH(4)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .async_in ({reset_terminal, run_cmd, external_fault_input,
                  coast_stop_input}),
      .sync_out (sync_q)
   );

   assign coast_s = sync_q[0];
   assign fault_s = sync_q[1];
   assign run_s   = sync_q[2];
   assign rst_s   = sync_q[3];

   // Edges from synchronised samples only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_prev_ff <= 1'b0;
         run_prev_ff   <= 1'b0;
         rst_prev_ff   <= 1'b0;
      end else if (ce) begin
         fault_prev_ff <= fault_s;
         run_prev_ff   <= run_s;
         rst_prev_ff   <= rst_s;
      end
   end
   assign fault_rise = fault_s & ~fault_prev_ff;
   assign run_rise   = run_s & ~run_prev_ff;
   assign rst_fall   = ~rst_s & rst_prev_ff;
   assign clear_req  = rst_s | sw_reset_ff;

   // APB: zero wait states, unmapped reads zero with an error
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   always_comb begin
      addr_ok = 1'b1;
      case (paddr)
         `CSTRIP_OFF_CTRL:     nxt_prdata = {29'h0, sw_reset_ff,
                                             lockout_ff, speed_sel_ff};
         `CSTRIP_OFF_DELAY:    nxt_prdata = {16'h0, delay_ff};
         `CSTRIP_OFF_STATUS:   nxt_prdata = {24'h0, 3'h0, state_ff};
         `CSTRIP_OFF_IRQ_STAT: nxt_prdata = {29'h0, irq_stat_ff};
         `CSTRIP_OFF_IRQ_MASK: nxt_prdata = {29'h0, irq_mask_ff};
         `CSTRIP_OFF_ERROR:    nxt_prdata = {24'h0, error_code};
         default: begin
            nxt_prdata = 32'h0;
            addr_ok    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else if (ce) begin
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            pslverr <= ~addr_ok;
         end
         if (rd_en) begin
            prdata <= nxt_prdata;
         end
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_sel_ff <= 1'b0;
         lockout_ff   <= 1'b0;
         sw_reset_ff  <= 1'b0;
         delay_ff     <= `CSTRIP_DELAY_RESET;
         irq_mask_ff  <= 3'h0;
      end else if (ce && wr_en && pready) begin
         case (paddr)
            `CSTRIP_OFF_CTRL: begin
               speed_sel_ff <= pwdata[`CSTRIP_CTRL_SPEED_BIT];
               lockout_ff   <= pwdata[`CSTRIP_CTRL_LOCKOUT_BIT];
               sw_reset_ff  <= pwdata[`CSTRIP_CTRL_RESET_BIT];
            end
            `CSTRIP_OFF_DELAY:    delay_ff    <= pwdata[15:0];
            `CSTRIP_OFF_IRQ_MASK: irq_mask_ff <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Sticky status, write one to clear; a new event wins over clear
   assign irq_evt[`CSTRIP_IRQ_TRIP_BIT]   = (nxt_state ==
                                            cstrip_pkg::CSTRIP_ST_TRIP) &&
                                           (state_ff !=
                                            cstrip_pkg::CSTRIP_ST_TRIP);
   assign irq_evt[`CSTRIP_IRQ_COAST_BIT]  = (nxt_state ==
                                            cstrip_pkg::CSTRIP_ST_COAST) &&
                                           (state_ff ==
                                            cstrip_pkg::CSTRIP_ST_RUN);
   assign irq_evt[`CSTRIP_IRQ_RESUME_BIT] = (nxt_state ==
                                            cstrip_pkg::CSTRIP_ST_RUN) &&
                                           (state_ff !=
                                            cstrip_pkg::CSTRIP_ST_RUN);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= 3'h0;
      end else if (ce) begin
         if (wr_en && pready && paddr == `CSTRIP_OFF_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata[2:0]) | irq_evt;
         end else begin
            irq_stat_ff <= irq_stat_ff | irq_evt;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // Delay base tick, counts units of the restart delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_ff <= 32'h0;
      end else if (ce) begin
         if (state_ff != cstrip_pkg::CSTRIP_ST_WAIT || tick) begin
            tick_cnt_ff <= 32'h0;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
         end
      end
   end
   assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

   // Operating state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         cstrip_pkg::CSTRIP_ST_STOP: begin
            if (run_s && armed_ff && !coast_s && !clear_req) begin
               nxt_state = cstrip_pkg::CSTRIP_ST_RUN;
            end
         end
         cstrip_pkg::CSTRIP_ST_RUN: begin
            if (coast_s) begin
               nxt_state = cstrip_pkg::CSTRIP_ST_COAST;
            end else if (!run_s) begin
               nxt_state = cstrip_pkg::CSTRIP_ST_STOP;
            end
         end
         cstrip_pkg::CSTRIP_ST_COAST: begin
            if (!coast_s) begin
               if (!run_s) begin
                  nxt_state = cstrip_pkg::CSTRIP_ST_STOP;
               end else if (delay_ff == 16'h0) begin
                  nxt_state = cstrip_pkg::CSTRIP_ST_RUN;
               end else begin
                  nxt_state = cstrip_pkg::CSTRIP_ST_WAIT;
               end
            end
         end
         cstrip_pkg::CSTRIP_ST_WAIT: begin
            if (coast_s) begin
               nxt_state = cstrip_pkg::CSTRIP_ST_COAST;
            end else if (!run_s) begin
               nxt_state = cstrip_pkg::CSTRIP_ST_STOP;
            end else if (delay_ff == 16'h0 ||
                         (tick && delay_cnt_ff >= delay_ff - 16'h1)) begin
               nxt_state = cstrip_pkg::CSTRIP_ST_RUN;
            end
         end
         cstrip_pkg::CSTRIP_ST_TRIP: begin
            if (clear_req) begin
               nxt_state = cstrip_pkg::CSTRIP_ST_STOP;
            end
         end
         default: nxt_state = cstrip_pkg::CSTRIP_ST_STOP;
      endcase
      // Trip outranks everything except an active clear
      if (fault_rise && !clear_req) begin
         nxt_state = cstrip_pkg::CSTRIP_ST_TRIP;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= cstrip_pkg::CSTRIP_ST_STOP;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_cnt_ff <= 16'h0;
      end else if (ce) begin
         if (state_ff != cstrip_pkg::CSTRIP_ST_WAIT) begin
            delay_cnt_ff <= 16'h0;
         end else if (tick) begin
            delay_cnt_ff <= delay_cnt_ff + 16'h1;
         end
      end
   end

   // Restart permission after a cleared trip; lockout needs fresh intent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_ff <= 1'b1;
      end else if (ce) begin
         if (nxt_state == cstrip_pkg::CSTRIP_ST_TRIP) begin
            armed_ff <= 1'b0;
         end else if (state_ff == cstrip_pkg::CSTRIP_ST_TRIP) begin
            armed_ff <= 1'b0;
         end else if (!rst_s && (!lockout_ff || run_rise || rst_fall ||
                                 !run_s)) begin
            armed_ff <= 1'b1;
         end
      end
   end

   // Outputs, each from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_enable     <= 1'b0;
         start_from_speed <= 1'b0;
         decel_stop       <= 1'b0;
      end else if (ce) begin
         drive_enable <= (nxt_state == cstrip_pkg::CSTRIP_ST_RUN);
         if (nxt_state == cstrip_pkg::CSTRIP_ST_RUN &&
             state_ff != cstrip_pkg::CSTRIP_ST_RUN) begin
            start_from_speed <= speed_sel_ff &
                                (state_ff != cstrip_pkg::CSTRIP_ST_STOP);
         end
         decel_stop <= (state_ff == cstrip_pkg::CSTRIP_ST_RUN) &&
                       (nxt_state == cstrip_pkg::CSTRIP_ST_STOP);
      end
   end

   // Alarm and error held until a clear; fault release changes nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_out  <= 1'b0;
         error_code <= `CSTRIP_ERR_NONE;
      end else if (ce) begin
         if (nxt_state == cstrip_pkg::CSTRIP_ST_TRIP) begin
            alarm_out  <= 1'b1;
            error_code <= `CSTRIP_ERR_EXT;
         end else if (clear_req) begin
            alarm_out  <= 1'b0;
            error_code <= `CSTRIP_ERR_NONE;
         end
      end
   end
endmodule
`default_nettype wire

// [shared/cstrip_consts.svh]
/*
 Timing counts, register offsets, field positions and reset values
 for the coast-stop and external-trip controller.
 Assumes a 250 MHz pclk; included by bare name.
*/
`ifndef CSTRIP_CONSTS_SVH
`define CSTRIP_CONSTS_SVH

`define CSTRIP_CLK_MHZ        250
`define CSTRIP_DELAY_UNIT_US  100
`define CSTRIP_TICK_CYCLES    (`CSTRIP_DELAY_UNIT_US * `CSTRIP_CLK_MHZ)

`define CSTRIP_OFF_CTRL       12'h000
`define CSTRIP_OFF_DELAY      12'h004
`define CSTRIP_OFF_STATUS     12'h008
`define CSTRIP_OFF_IRQ_STAT   12'h00c
`define CSTRIP_OFF_IRQ_MASK   12'h010
`define CSTRIP_OFF_ERROR      12'h014

`define CSTRIP_CTRL_SPEED_BIT    0
`define CSTRIP_CTRL_LOCKOUT_BIT  1
`define CSTRIP_CTRL_RESET_BIT    2

`define CSTRIP_IRQ_TRIP_BIT      0
`define CSTRIP_IRQ_COAST_BIT     1
`define CSTRIP_IRQ_RESUME_BIT    2

`define CSTRIP_ERR_NONE       8'h00
`define CSTRIP_ERR_EXT        8'h0c
`define CSTRIP_DELAY_RESET    16'h0000

`endif

// [shared/cstrip_pkg.sv]
/*
 Types for the coast-stop and external-trip controller.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cstrip_pkg;
   typedef enum logic [4:0] {
      CSTRIP_ST_STOP  = 5'b00001,
      CSTRIP_ST_RUN   = 5'b00010,
      CSTRIP_ST_COAST = 5'b00100,
      CSTRIP_ST_WAIT  = 5'b01000,
      CSTRIP_ST_TRIP  = 5'b10000
   } cstrip_state_t;
endpackage
`default_nettype wire

// [hw/cstrip_sync.sv]
/*
 Two-flop synchroniser, one per bit, for terminal inputs.
 Assumes inputs asynchronous to pclk; freezes while ce is low.
*/
`timescale 1ns/1ps
`default_nettype none
module cstrip_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_ff[i]  <= 1'b0;
               sync_out[i] <= 1'b0;
            end else if (ce) begin
               meta_ff[i]  <= async_in[i];
               sync_out[i] <= meta_ff[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [dv/cstrip_monitor.sv]
/*
 Port checker for the coast-stop and external-trip controller.
 Assumes one pclk domain and bind to cstrip_top.
*/
`timescale 1ns/1ps
`default_nettype none
module cstrip_monitor (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       ce,
   input wire logic       coast_stop_input,
   input wire logic       external_fault_input,
   input wire logic       run_cmd,
   input wire logic       reset_terminal,
   input wire logic       drive_enable,
   input wire logic       decel_stop,
   input wire logic       alarm_out,
   input wire logic [7:0] error_code
);
   default clocking cb @(posedge pclk); endclocking
   // Frozen state under ce low, so stop judging then
   default disable iff (!presetn || !ce);
   chk_error_code: assert property (
      error_code == (alarm_out ? 8'h0c : 8'h00))
      else $error("error code disagrees with alarm");
   chk_coast_off: assert property (
      coast_stop_input [*6] |-> !drive_enable)
      else $error("drive on during coast stop");
   chk_trip_off: assert property (
      alarm_out [*2] |-> !drive_enable)
      else $error("drive on while tripped");
   chk_fault_edge: assert property (
      $rose(external_fault_input) && !reset_terminal ##1
      !reset_terminal [*6] |-> ##[0:2] alarm_out)
      else $error("fault edge missed");
   chk_fault_fall: assert property (
      $fell(external_fault_input) && alarm_out |=> alarm_out)
      else $error("fault release cleared trip");
   chk_clear_stop: assert property (
      reset_terminal [*6] |-> !alarm_out && !drive_enable)
      else $error("clear did not stop");
   chk_run_low: assert property (
      !run_cmd [*6] |-> !drive_enable)
      else $error("drive without run command");
   chk_decel_pulse: assert property (
      decel_stop |-> ($past(drive_enable) || $past(drive_enable, 2))
      ##1 !decel_stop)
      else $error("bad controlled stop pulse");
   cover property ($rose(alarm_out));
   cover property ($rose(drive_enable));
   cover property (decel_stop);
endmodule
bind cstrip_top cstrip_monitor u_mon (
   .pclk                 (pclk),
   .presetn              (presetn),
   .ce                   (ce),
   .coast_stop_input     (coast_stop_input),
   .external_fault_input (external_fault_input),
   .run_cmd              (run_cmd),
   .reset_terminal       (reset_terminal),
   .drive_enable         (drive_enable),
   .decel_stop           (decel_stop),
   .alarm_out            (alarm_out),
   .error_code           (error_code)
);
`default_nettype wire

// [dv/cstrip_stage_model.sv]
/*
 Output stage and motor: speed climbs while driven, coasts down.
 Assumes drive_enable from the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module cstrip_stage_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       drive_enable,
   output logic      [7:0] speed_ff
);
   // No braking: losing drive only lets the motor coast
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) speed_ff <= 8'h00;
      else if (drive_enable && speed_ff != 8'hff) speed_ff <= speed_ff + 8'h01;
      else if (!drive_enable && speed_ff != 8'h00) speed_ff <= speed_ff - 8'h01;
   end
endmodule
`default_nettype wire

// [dv/test_coast_stop_and_external_trip.sv]
/*
 Bench: APB tasks and pin sequences with expected values.
 Assumes cstrip_top with TICK_CYCLES 4, bound checker and stage model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
 $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_coast_stop_and_external_trip;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic coast, fault, run, rst, drive, sfs, decel, alarm, seen, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] ecode, speed;
   int num_errors = 0, comparisons = 0, n;
   cstrip_top #(.TICK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .coast_stop_input(coast),
      .external_fault_input(fault), .run_cmd(run), .reset_terminal(rst),
      .drive_enable(drive), .start_from_speed(sfs), .decel_stop(decel),
      .alarm_out(alarm), .error_code(ecode), .irq(irq));
   cstrip_stage_model u_stage (.pclk(pclk), .presetn(presetn),
      .drive_enable(drive), .speed_ff(speed));
   always #2 pclk = ~pclk;
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CMP(q, e)
   endtask
   // Pins pass two sync flops and a state flop; eight edges is margin
   task settle;
      repeat (8) @(posedge pclk);
   endtask
   task cnt_drive;
      n = 0;
      while (drive !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      report_and_stop;
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, coast, fault, run, rst} = 0;
      ce = 1'b1;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rdc(12'(i * 4), 32'(i == 2));
      rdc(12'h0fc, 32'h0);
      `CMP(err, 1'b1)
      $display("test reset done");
      apb(1'b1, 12'h010, 32'h7);
      run <= 1'b1;
      settle;
      `CMP(drive, 1'b1)
      `CMP(sfs, 1'b0)
      `CMP(irq, 1'b1)
      `CMP(speed != 8'h00, 1'b1)
      apb(1'b1, 12'h00c, 32'h4);
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h004, 32'h2);
      `CMP(irq, 1'b0)
      $display("test run done");
      coast <= 1'b1;
      settle;
      `CMP(drive, 1'b0)
      rdc(12'h008, 32'h4);
      rdc(12'h00c, 32'h2);
      `CMP(irq, 1'b0)
      coast <= 1'b0;
      cnt_drive;
      // Two delay units of four cycles plus input latency
      `CMP(n >= 10 && n <= 18, 1'b1)
      `CMP(sfs, 1'b1)
      apb(1'b1, 12'h004, 32'h0);
      coast <= 1'b1;
      settle;
      coast <= 1'b0;
      cnt_drive;
      `CMP(n <= 7, 1'b1)
      $display("test coast done");
      run <= 1'b0;
      seen = 1'b0;
      repeat (10) begin
         @(posedge pclk);
         seen |= decel;
      end
      `CMP(seen, 1'b1)
      run <= 1'b1;
      settle;
      coast <= 1'b1;
      settle;
      run <= 1'b0;
      settle;
      coast <= 1'b0;
      settle;
      `CMP(drive, 1'b0)
      rdc(12'h008, 32'h1);
      $display("test release done");
      apb(1'b1, 12'h000, 32'h0);
      run <= 1'b1;
      settle;
      fault <= 1'b1;
      settle;
      `CMP(alarm, 1'b1)
      `CMP(ecode, 8'h0c)
      `CMP(drive, 1'b0)
      rdc(12'h014, 32'h0c);
      rdc(12'h008, 32'h10);
      rdc(12'h00c, 32'h7);
      fault <= 1'b0;
      settle;
      `CMP(alarm, 1'b1)
      rst <= 1'b1;
      settle;
      `CMP(alarm, 1'b0)
      rdc(12'h008, 32'h1);
      rst <= 1'b0;
      settle;
      `CMP(drive, 1'b1)
      $display("test trip done");
      apb(1'b1, 12'h000, 32'h2);
      fault <= 1'b1;
      settle;
      fault <= 1'b0;
      apb(1'b1, 12'h000, 32'h6);
      settle;
      `CMP(alarm, 1'b0)
      apb(1'b1, 12'h000, 32'h2);
      settle;
      `CMP(drive, 1'b0)
      run <= 1'b0;
      settle;
      run <= 1'b1;
      settle;
      `CMP(drive, 1'b1)
      fault <= 1'b1;
      settle;
      fault <= 1'b0;
      rst <= 1'b1;
      settle;
      `CMP(alarm, 1'b0)
      rst <= 1'b0;
      settle;
      `CMP(drive, 1'b1)
      $display("test lockout done");
      report_and_stop;
   end
endmodule
`default_nettype wire
